/* pwrg_pkg.sv */
// Purpose: constants for the pulse-width reload and start-source block
// Assumes: classic Wishbone, 32-bit data, one word per register
// Notes:   offsets are byte addresses
`default_nettype none
package pwrg_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [7:0] WIDTHS_BASE   = 8'h00;   // ch n at base + 4n
  localparam logic [7:0] SRC_BASE      = 8'h60;   // quad q at base + 4q
  localparam logic [7:0] MODE_BASE     = 8'h80;   // quad q at base + 4q
  localparam logic [7:0] START_OFS     = 8'hA0;   // software start bits, one per pair
  localparam logic [7:0] TIMING_OFS    = 8'hA4;   // timing trigger bits
  localparam logic [7:0] OUT_OFS       = 8'hA8;   // output levels
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int HIGH_LSB       = 8;
  localparam int LOWER_GATE_BIT = 1;
  localparam int UPPER_GATE_BIT = 5;
  localparam logic [7:0] SRC_WMASK = 8'h22;       // only gate selects stored
  // mode register per quad: [1:0] lower mode [3:2] upper mode
  // [5:4] lower clk [7:6] upper clk [8] lower timing [9] upper timing
  localparam int MODE_W = 10;
  localparam logic [1:0] MD_8     = 2'h0;
  localparam logic [1:0] MD_8P8   = 2'h1;
  localparam logic [1:0] MD_16    = 2'h2;
  localparam logic [1:0] MD_16P16 = 2'h3;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] SRC_RESET = 8'h00;
  localparam logic [MODE_W-1:0] MODE_RESET = 10'h000;
  localparam logic [5:0] DIV4_LAST  = 6'h03;
  localparam logic [5:0] DIV16_LAST = 6'h0F;
  localparam logic [5:0] DIV64_LAST = 6'h3F;
endpackage : pwrg_pkg
`default_nettype wire

/* pwrg_top.sv */
// Purpose: 24-channel pulse width reload, pair modes and start selection
// Assumes: classic Wishbone slave, inputs synchronous to i_sys_clk
// Notes:   lower 12 bits of start/timing registers and the gate input are channel pairs
`default_nettype none
module pwrg_top #(
  parameter int NCH = 24
) (
  input  wire logic            i_sys_clk,
  input  wire logic            i_rstn,
  input  wire logic            i_wb_cyc,
  input  wire logic            i_wb_stb,
  input  wire logic            i_wb_we,
  input  wire logic [7:0]      i_wb_adr,
  input  wire logic [3:0]      i_wb_sel,
  input  wire logic [31:0]     i_wb_dat,
  output logic      [31:0]     o_wb_dat,
  output logic                 o_wb_ack,
  input  wire logic [NCH/2-1:0] i_timer_gate,
  output logic      [NCH-1:0]  o_pulse
);
  localparam int NP = NCH / 2;
  localparam int NQ = NCH / 4;
  // only the documented channel count is served by the routing below
  if (NCH != 24) begin : g_nch_check
    $error("pwrg_top: NCH must be 24");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [15:0]       widths_ff [NCH];
  logic [15:0]       nxt_widths [NCH];
  logic [7:0]        src_ff [NQ];
  logic [7:0]        nxt_src [NQ];
  logic [pwrg_pkg::MODE_W-1:0] mode_ff [NQ];
  logic [pwrg_pkg::MODE_W-1:0] nxt_mode [NQ];
  logic [NP-1:0]     sw_start_ff, nxt_sw_start;
  logic [NP-1:0]     tim_start_ff, nxt_tim_start;
  logic              ack_ff, nxt_ack;
  logic [31:0]       rdat_ff, nxt_rdat;
  logic [5:0]        div_ff, nxt_div;
  logic [15:0]       cnt_ff [NCH];
  logic [15:0]       nxt_cnt [NCH];
  logic [15:0]       hbuf_ff [NCH];
  logic [15:0]       nxt_hbuf [NCH];
  logic [NCH-1:0]    out_ff, nxt_out;
  logic [NCH-1:0]    run_ff, nxt_run;

  // decode of a register word address at base + 4 * idx
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] base,
                               input int idx);
    hit = (adr == 8'(base + 8'(idx * 4)));
  endfunction : hit

  // tick for a two-bit clock select, from the shared divider
  function automatic logic tick(input logic [1:0] sel, input logic [5:0] d);
    unique case (sel)
      2'h0: tick = 1'b1;
      2'h1: tick = (d[1:0] == pwrg_pkg::DIV4_LAST[1:0]);
      2'h2: tick = (d[3:0] == pwrg_pkg::DIV16_LAST[3:0]);
      2'h3: tick = (d == pwrg_pkg::DIV64_LAST);
    endcase
  endfunction : tick

  // ---------------------------------------------------------------
  // wishbone slave: one wait state, ack for every address
  // ---------------------------------------------------------------
  logic req;
  assign req = i_wb_cyc && i_wb_stb && !ack_ff;

  // register writes and read mux
  always_comb begin
    logic [31:0] wm;
    wm = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}}, {8{i_wb_sel[1]}},
          {8{i_wb_sel[0]}}};
    nxt_ack       = req;
    nxt_rdat      = 32'h0000_0000;   // unmapped reads return zero
    nxt_sw_start  = sw_start_ff;
    nxt_tim_start = tim_start_ff;
    for (int c = 0; c < NCH; c++) begin
      nxt_widths[c] = widths_ff[c];
      if (req && hit(i_wb_adr, pwrg_pkg::WIDTHS_BASE, c)) begin
        nxt_rdat = {16'h0000, widths_ff[c]};
        if (i_wb_we) begin
          nxt_widths[c] = (widths_ff[c] & ~wm[15:0])
                        | (i_wb_dat[15:0] & wm[15:0]);
        end
      end
    end
    for (int q = 0; q < NQ; q++) begin
      nxt_src[q]  = src_ff[q];
      nxt_mode[q] = mode_ff[q];
      if (req && hit(i_wb_adr, pwrg_pkg::SRC_BASE, q)) begin
        nxt_rdat = {24'h00_0000, src_ff[q]};
        if (i_wb_we && i_wb_sel[0]) begin
          nxt_src[q] = i_wb_dat[7:0] & pwrg_pkg::SRC_WMASK;
        end
      end
      if (req && hit(i_wb_adr, pwrg_pkg::MODE_BASE, q)) begin
        nxt_rdat = {22'h0_0000, mode_ff[q]};
        if (i_wb_we) begin
          nxt_mode[q] = (mode_ff[q] & ~wm[9:0]) | (i_wb_dat[9:0] & wm[9:0]);
        end
      end
    end
    if (req && i_wb_adr == pwrg_pkg::START_OFS) begin
      nxt_rdat = {20'h0_0000, sw_start_ff};
      if (i_wb_we) begin
        nxt_sw_start = (sw_start_ff & ~wm[11:0])
                     | (i_wb_dat[11:0] & wm[11:0]);
      end
    end
    if (req && i_wb_adr == pwrg_pkg::TIMING_OFS) begin
      nxt_rdat = {20'h0_0000, tim_start_ff};
      if (i_wb_we) begin
        nxt_tim_start = (tim_start_ff & ~wm[11:0])
                      | (i_wb_dat[11:0] & wm[11:0]);
      end
    end
    if (req && i_wb_adr == pwrg_pkg::OUT_OFS) begin
      nxt_rdat = {8'h00, out_ff};
    end
  end

  // register bank; widths are left unreset, as the hardware leaves them
  always_ff @(posedge i_sys_clk) begin
    for (int c = 0; c < NCH; c++) begin
      widths_ff[c] <= nxt_widths[c];
    end
  end

  // control registers and bus answer
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int q = 0; q < NQ; q++) begin
        src_ff[q]  <= pwrg_pkg::SRC_RESET;
        mode_ff[q] <= pwrg_pkg::MODE_RESET;
      end
      sw_start_ff  <= '0;
      tim_start_ff <= '0;
      ack_ff       <= 1'b0;
      rdat_ff      <= 32'h0000_0000;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        src_ff[q]  <= nxt_src[q];
        mode_ff[q] <= nxt_mode[q];
      end
      sw_start_ff  <= nxt_sw_start;
      tim_start_ff <= nxt_tim_start;
      ack_ff       <= nxt_ack;
      rdat_ff      <= nxt_rdat;
    end
  end
  assign o_wb_ack = ack_ff;
  assign o_wb_dat = rdat_ff;
  assign o_pulse  = out_ff;

  // ---------------------------------------------------------------
  // pulse generators
  // ---------------------------------------------------------------
  logic [NP-1:0]  pair_start;
  logic [NCH-1:0] en, uf;
  logic [15:0]    hi_w [NCH];
  logic [15:0]    lo_w [NCH];
  logic [NCH-1:0] wide;
  logic [1:0]     pmode [NP];

  // start source, pair mode and width routing
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      logic [pwrg_pkg::MODE_W-1:0] m;
      logic gsel, tsel;
      m = mode_ff[p/2];
      pmode[p] = (p % 2 == 0) ? m[1:0] : m[3:2];
      gsel = (p % 2 == 0) ? src_ff[p/2][pwrg_pkg::LOWER_GATE_BIT]
                          : src_ff[p/2][pwrg_pkg::UPPER_GATE_BIT];
      tsel = (p % 2 == 0) ? m[8] : m[9];
      if (tsel) begin
        pair_start[p] = tim_start_ff[p];
      end else if (gsel) begin
        pair_start[p] = i_timer_gate[p];
      end else begin
        pair_start[p] = sw_start_ff[p];
      end
    end
    for (int c = 0; c < NCH; c++) begin
      logic [1:0] md;
      int e;
      e  = c - (c % 2);
      md = pmode[c/2];
      // 16+16 pairs the quad's lower mode for both pairs
      if (pmode[(c/4)*2] == pwrg_pkg::MD_16P16) begin
        md = pwrg_pkg::MD_16P16;
      end
      wide[c] = (md == pwrg_pkg::MD_16) || (md == pwrg_pkg::MD_16P16);
      if (wide[c]) begin
        hi_w[c] = widths_ff[e];
        lo_w[c] = widths_ff[e+1];
      end else begin
        hi_w[c] = {8'h00,
                   widths_ff[c][15:pwrg_pkg::HIGH_LSB]};
        lo_w[c] = {8'h00, widths_ff[c][7:0]};
      end
    end
    for (int c = 0; c < NCH; c++) begin
      logic [1:0] md, cs;
      logic [pwrg_pkg::MODE_W-1:0] m;
      m  = mode_ff[c/4];
      md = pmode[c/2];
      cs = ((c/2) % 2 == 0) ? m[5:4] : m[7:6];
      en[c] = tick(cs, div_ff);
      if (md == pwrg_pkg::MD_8P8 && c % 2 == 0) begin
        en[c] = uf[c+1] && out_ff[c+1];
      end
      if (pmode[(c/4)*2] == pwrg_pkg::MD_16P16 && (c % 4) < 2) begin
        en[c] = uf[(c/4)*4+2] && out_ff[(c/4)*4+2];
      end
      if (wide[c] && c % 2 == 1) begin
        en[c] = en[c-1];
      end
    end
  end

  // per-channel running state, buffered high width, counter
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      uf[c] = run_ff[c] && en[c] && (cnt_ff[c] == 16'h0000);
    end
    for (int c = 0; c < NCH; c++) begin
      logic go;
      go = pair_start[c/2];
      nxt_run[c]  = go;
      nxt_hbuf[c] = hbuf_ff[c];
      nxt_cnt[c]  = cnt_ff[c];
      nxt_out[c]  = out_ff[c];
      if (!go) begin
        nxt_out[c]  = 1'b0;
        nxt_cnt[c]  = lo_w[c];                      // first phase is low
        nxt_hbuf[c] = hi_w[c];
      end else if (uf[c]) begin
        nxt_out[c] = !out_ff[c];
        if (out_ff[c]) begin
          nxt_cnt[c]  = lo_w[c];
          nxt_hbuf[c] = hi_w[c];
        end else begin
          nxt_cnt[c] = hbuf_ff[c];
        end
      end else if (run_ff[c] && en[c]) begin
        nxt_cnt[c] = 16'(cnt_ff[c] - 16'h0001);
      end
    end
    nxt_div = 6'(div_ff + 6'h01);
  end

  // generator registers; reset stops every channel
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      for (int c = 0; c < NCH; c++) begin
        cnt_ff[c]  <= 16'h0000;
        hbuf_ff[c] <= 16'h0000;
      end
      out_ff <= '0;
      run_ff <= '0;
      div_ff <= 6'h00;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        cnt_ff[c]  <= nxt_cnt[c];
        hbuf_ff[c] <= nxt_hbuf[c];
      end
      out_ff <= nxt_out;
      run_ff <= nxt_run;
      div_ff <= nxt_div;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_stop;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !pair_start[0] |=> !o_pulse[0] && !run_ff[0];
  endproperty
  a_stop: assert property (p_stop) else $error("stop not honoured");
  property p_src_zero;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      (src_ff[0] & ~pwrg_pkg::SRC_WMASK) == 8'h00;
  endproperty
  a_src_zero: assert property (p_src_zero) else $error("reserved set");
  property p_toggle;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      uf[0] && pair_start[0] |=> o_pulse[0] != $past(o_pulse[0]);
  endproperty
  a_toggle: assert property (p_toggle) else $error("no toggle");
  property p_hold;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !uf[0] && $past(pair_start[0]) && pair_start[0] && run_ff[0]
      |=> $stable(o_pulse[0]);
  endproperty
  a_hold: assert property (p_hold) else $error("early toggle");
  property p_gate;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      src_ff[0][pwrg_pkg::LOWER_GATE_BIT] && !mode_ff[0][8]
      |-> pair_start[0] == i_timer_gate[0];
  endproperty
  a_gate: assert property (p_gate) else $error("gate source");
  property p_sw;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      !src_ff[0][pwrg_pkg::UPPER_GATE_BIT] && !mode_ff[0][9]
      |-> pair_start[1] == sw_start_ff[1];
  endproperty
  a_sw: assert property (p_sw) else $error("software source");
  property p_tim;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      mode_ff[0][8] |-> pair_start[0] == tim_start_ff[0];
  endproperty
  a_tim: assert property (p_tim) else $error("timing source");
  property p_load_low;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      uf[0] && o_pulse[0] && pair_start[0] |=> cnt_ff[0] == $past(lo_w[0]);
  endproperty
  a_load_low: assert property (p_load_low) else $error("low reload");
  property p_ack;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      o_wb_ack |=> !o_wb_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held");

  // ---------------------------------------------------------------
  // start, reload and buffer sequences
  // ---------------------------------------------------------------
  // steps of a start, a low-to-high reload and a held reset
  sequence s_begin;
    !run_ff[0] && pair_start[0];
  endsequence
  sequence s_first_low;
    run_ff[0] && !o_pulse[0];
  endsequence
  sequence s_low_end;
    uf[0] && !o_pulse[0] && pair_start[0];
  endsequence
  sequence s_held_reset;
    !i_rstn ##1 !i_rstn;
  endsequence
  property p_go;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_begin |=> s_first_low;
  endproperty
  a_go: assert property (p_go) else $error("bad start");
  property p_hload;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      s_low_end |=> o_pulse[0] && cnt_ff[0] == $past(hbuf_ff[0]);
  endproperty
  a_hload: assert property (p_hload) else $error("high reload");
  property p_hkeep;
    @(posedge i_sys_clk) disable iff (!i_rstn)
      run_ff[0] && pair_start[0] && !(uf[0] && o_pulse[0])
      |=> hbuf_ff[0] == $past(hbuf_ff[0]);
  endproperty
  a_hkeep: assert property (p_hkeep) else $error("buffer moved");
  property p_rst;
    @(posedge i_sys_clk)
      s_held_reset |-> o_pulse == '0 && !o_wb_ack;
  endproperty
  a_rst: assert property (p_rst) else $error("active in reset");
endmodule : pwrg_top
`default_nettype wire

/* pwrg_gate_model.sv */
// Purpose: gate levels from the multifunction timer, one per pair
// Assumes: the bench commands the wanted level on i_run
// Notes:   i_slow picks the long path of LAT cycles
`default_nettype none
module pwrg_gate_model #(
  parameter int LAT = 3
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_slow,
  input  wire logic [11:0] i_run,
  output logic      [11:0] o_gate
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [LAT*12-1:0] dly_ff;
  // delay line for the commanded gate levels
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      dly_ff <= '0;
    end else begin
      dly_ff <= {dly_ff[LAT*12-13:0], i_run};
    end
  end
  // prompt or slow gate, negated when the timer withdraws it
  assign o_gate = i_slow ? dly_ff[LAT*12-1 -: 12] : dly_ff[11:0];
endmodule : pwrg_gate_model
`default_nettype wire

/* testbench.sv */
// Purpose: register and waveform checks of the pulse reload block
// Assumes: one answer per bus request, released after ack
// Notes:   phase widths counted in clock cycles on falling edges
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MB = pwrg_pkg::MODE_BASE;
  localparam logic [7:0] SB = pwrg_pkg::SRC_BASE;
  localparam logic [7:0] GO = pwrg_pkg::START_OFS;
  logic        clk;
  logic        rstn;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic [31:0] rdat_q;
  logic        ack;
  logic        slow;
  logic [11:0] run;
  logic [11:0] gate;
  logic [23:0] pulse;
  int          n_errors;
  int          total_checks;

  pwrg_top pwrg_top_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_timer_gate(gate), .o_pulse(pulse)
  );
  pwrg_gate_model pwrg_gate_model_i (
    .i_sys_clk(clk), .i_rstn(rstn), .i_slow(slow), .i_run(run),
    .o_gate(gate)
  );

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // bus, compare and measuring tasks
  // ---------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hF};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    rdat_q = rdat;
    {cyc, stb} <= 2'b00;
    if (n >= 64) begin
      n_errors++;
      tally_and_finish();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input string what);
    bus(1'b0, a, 32'h0000_0000);
    check(what, rdat_q, e);
  endtask : rd

  task automatic wait_lvl(input int ch, input logic lv, output int cnt);
    cnt = 0;
    while (pulse[ch] !== lv) begin
      @(negedge clk);
      cnt++;
      if (cnt > 5000) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask : wait_lvl

  // align on a rising output, then count one high and one low phase
  task automatic meas(input int ch, input int hi, input int lo);
    int c;
    @(negedge clk);
    wait_lvl(ch, 1'b0, c);
    wait_lvl(ch, 1'b1, c);
    wait_lvl(ch, 1'b0, c);
    check("high phase", 32'(c), 32'(hi));
    wait_lvl(ch, 1'b1, c);
    check("low phase", 32'(c), 32'(lo));
  endtask : meas

  task automatic quiet(input logic [23:0] m);
    repeat (2) begin
      repeat (6) @(negedge clk);
      check("stopped", 32'(pulse & m), 32'h0000_0000);
    end
  endtask : quiet

  // main sequence
  initial begin
    int d;
    {rstn, cyc, stb, we, slow} = 5'h00;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0000_0000;
    run = 12'h000;
    n_errors = 0;
    total_checks = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(SB, 32'h0000_0000, "src reset");
    rd(8'hA8, 32'h0000_0000, "levels reset");
    check("pulse reset", 32'(pulse), 32'h0000_0000);
    for (int n = 0; n < 24; n++) begin
      wr(8'(4 * n), 32'(16'hA500 + 16'(n) * 16'h0101));
    end
    for (int n = 0; n < 24; n++) begin
      rd(8'(4 * n), 32'(16'hA500 + 16'(n) * 16'h0101), "widths");
    end
    wr(8'hFC, 32'h0000_FFFF);
    rd(8'hFC, 32'h0000_0000, "unmapped");
    wr(SB, 32'h0000_00FF);
    rd(SB, 32'h0000_0022, "src bits");
    wr(SB, 32'h0000_0000);
    // plain 8-bit pair, live width change, stop, reset mid-run
    wr(MB, 32'h0000_0000);
    wr(8'h00, 32'h0000_0203);
    wr(8'h04, 32'h0000_0001);
    wr(GO, 32'h0000_0001);
    meas(0, 3, 4);
    meas(1, 1, 2);
    wr(8'h00, 32'h0000_0503);
    repeat (30) @(negedge clk);
    meas(0, 6, 4);
    wr(GO, 32'h0000_0000);
    quiet(24'h00_0003);
    wr(GO, 32'h0000_0001);
    repeat (9) @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    check("pulse in reset", 32'(pulse), 32'h0000_0000);
    rstn <= 1'b1;
    quiet(24'hFF_FFFF);
    // count clock dividers 4, 16 and 64
    wr(8'h00, 32'h0000_0100);
    wr(8'h04, 32'h0000_0100);
    for (int s = 1; s < 4; s++) begin
      d = 4 ** s;
      wr(MB, 32'(s << 4));
      wr(GO, 32'h0000_0001);
      meas(0, 2 * d, d);
      wr(GO, 32'h0000_0000);
    end
    // chained 16-bit pair
    wr(MB, 32'h0000_0002);
    wr(8'h04, 32'h0000_0002);
    wr(GO, 32'h0000_0001);
    meas(0, 257, 3);
    check("odd mirror", 32'(pulse[1]), 32'(pulse[0]));
    meas(1, 257, 3);
    wr(GO, 32'h0000_0000);
    // 8+8 prescaled pair
    wr(MB, 32'h0000_0001);
    wr(8'h00, 32'h0000_0102);
    wr(8'h04, 32'h0000_0000);
    wr(GO, 32'h0000_0001);
    meas(0, 4, 6);
    meas(1, 1, 1);
    wr(GO, 32'h0000_0000);
    // 16+16 prescaled quad
    wr(MB, 32'h0000_0003);
    wr(8'h00, 32'h0000_0001);
    wr(8'h08, 32'h0000_0000);
    wr(8'h0C, 32'h0000_0001);
    wr(GO, 32'h0000_0003);
    rd(GO, 32'h0000_0003, "start bits");
    meas(0, 6, 3);
    wr(GO, 32'h0000_0000);
    // gate start, lower pair prompt, upper pair slow
    wr(MB, 32'h0000_0000);
    wr(8'h00, 32'h0000_0101);
    wr(8'h08, 32'h0000_0101);
    wr(SB, 32'h0000_0002);
    wr(GO, 32'h0000_0001);
    quiet(24'h00_0003);
    @(posedge clk);
    run <= 12'h001;
    meas(0, 2, 2);
    @(posedge clk);
    run <= 12'h000;
    quiet(24'h00_0003);
    wr(SB, 32'h0000_0020);
    wr(GO, 32'h0000_0002);
    quiet(24'h00_000C);
    @(posedge clk);
    slow <= 1'b1;
    run <= 12'h002;
    meas(2, 2, 2);
    @(posedge clk);
    run <= 12'h000;
    quiet(24'h00_000C);
    // timing generator start
    wr(SB, 32'h0000_0000);
    wr(GO, 32'h0000_0000);
    wr(MB, 32'h0000_0100);
    rd(MB, 32'h0000_0100, "mode");
    wr(pwrg_pkg::TIMING_OFS, 32'h0000_0001);
    rd(pwrg_pkg::TIMING_OFS, 32'h0000_0001, "timing bits");
    meas(0, 2, 2);
    wr(pwrg_pkg::TIMING_OFS, 32'h0000_0000);
    quiet(24'h00_0001);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
